/* File: rtl/dac_path_pkg.sv */
//==============================================================
// Contract
// - accept one 32-bit word per cycle
// - redirector feeds fifo; read after start
// - control bits 5..4 select redirector path
// - fifo data multiplexed to ports A, B
// - clock LED green ok, red on fault
// - bus LED: access green, ack red
// - routing LED shows redirector setting
// - status 27 flags fifo overrun/underrun
// - status 26..24 full, half, empty
// - status 21 flags received data valid
// - status 16 flags start event seen
// - status 0 shows synthesizer lock
// - control bit 31 resets board, except ports A, B
// - control 21..20 selects trigger source
// - control bit 12 holds link reset
// - control bit 0 enables capture
// - version: unit code and firmware number
// - stop address holds last ring write
// - four samples per word, oldest high
// - device is slave, peer drives data
package dac_path_pkg;
  // register offsets
  localparam logic [11:0] STATUS_OFS = 12'h000;
  localparam logic [11:0] CONTROL_OFS = 12'h010;
  localparam logic [11:0] VERSION_OFS = 12'h020;
  localparam logic [11:0] STOP_ADDR_OFS = 12'h040;
  localparam logic [11:0] LAST_ADDR_OFS = 12'h110;
  // status bit positions
  localparam int ST_OVERRUN = 27;
  localparam int ST_FULL = 26;
  localparam int ST_HALF = 25;
  localparam int ST_EMPTY = 24;
  localparam int ST_DVALID = 21;
  localparam int ST_START = 16;
  localparam int ST_LOCK = 0;
  // control bit positions
  localparam int CT_BOARD_RST = 31;
  localparam int CT_MODE_HI = 21;
  localparam int CT_MODE_LO = 20;
  localparam int CT_LINK_RST = 12;
  localparam int CT_SW_TRIG = 8;
  localparam int CT_ROUTE_HI = 5;
  localparam int CT_ROUTE_LO = 4;
  localparam int CT_ENABLE = 0;
  // control reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] ROUTE_RST = 2'h0;
  localparam logic LINK_RST_RST = 1'b1;
  // trigger source encodings
  localparam logic [1:0] MODE_EXT = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;
  // redirector encodings
  localparam logic [1:0] ROUTE_BOTH = 2'h0;
  localparam logic [1:0] ROUTE_DAC = 2'h1;
  localparam logic [1:0] ROUTE_RING2DAC = 2'h2;
  localparam logic [1:0] ROUTE_RING = 2'h3;
  // LED colours {red, green}
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED = 2'h2;
  localparam logic [1:0] LED_YELLOW = 2'h3;
  // version field positions
  localparam int VER_UNIT_LO = 16;
endpackage

/* File: rtl/dac_output_path.sv */
`timescale 1ns/1ns
module dac_output_path
  import dac_path_pkg::*;
#(
  parameter int DEPTH_LOG2 = 4,
  parameter int RING_AW = 20,
  parameter logic [RING_AW-1:0] LAST_ADDR_RST = 20'hFFFEF,
  parameter logic [11:0] UNIT_CODE = 12'h5A7,   // arbitrary value
  parameter logic [15:0] FW_VERSION = 16'h0001  // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic regSel,
  input wire logic regWrite,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regAck,
  // data link from daughter board
  input wire logic [31:0] fpdpData,
  input wire logic fpdpDvalid,
  input wire logic fpdpStrobe,
  output logic linkReset,
  // start event and clock health
  input wire logic startEvent,
  input wire logic clkLocked,
  input wire logic clkFault,
  // ring memory
  output logic ringWrEn,
  output logic [RING_AW-1:0] ringAddr,
  output logic [31:0] ringWrData,
  input wire logic [31:0] ringRdData,
  // output ports
  output logic [7:0] portA,
  output logic [7:0] portB,
  output logic outValid,
  // LEDs, {red, green}
  output logic [1:0] ledClock,
  output logic [1:0] ledBus,
  output logic [1:0] ledRoute
);

  //============================================================
  // state
  localparam int DEPTH = 1 << DEPTH_LOG2;
  localparam logic [DEPTH_LOG2:0] HALF_LEVEL = (DEPTH_LOG2+1)'(DEPTH / 2);
  localparam logic [DEPTH_LOG2:0] FULL_LEVEL = (DEPTH_LOG2+1)'(DEPTH);

  logic [31:0] mem_q [DEPTH];          // fifo storage
  logic [DEPTH_LOG2-1:0] wrPtr_q, wrPtr_d;
  logic [DEPTH_LOG2-1:0] rdPtr_q, rdPtr_d;
  logic [DEPTH_LOG2:0] level_q, level_d;
  logic overrun_q, overrun_d;          // sticky fifo error
  logic dvalidSeen_q, dvalidSeen_d;    // sticky data valid
  logic started_q, started_d;          // start event caught
  logic [1:0] mode_q, mode_d;          // trigger source
  logic [1:0] route_q, route_d;        // redirector path
  logic linkRst_q, linkRst_d;          // link held in reset
  logic enable_q, enable_d;            // capture enable
  logic boardRst_q, boardRst_d;        // board reset pending
  logic [RING_AW-1:0] ringPtr_q, ringPtr_d;
  logic [RING_AW-1:0] stopAddr_q, stopAddr_d;
  logic [RING_AW-1:0] lastAddr_q, lastAddr_d;
  logic [RING_AW-1:0] ringWrAddr_q, ringWrAddr_d;  // address of the pending write
  logic [31:0] outWord_q, outWord_d;   // word being serialised
  logic secondHalf_q, secondHalf_d;    // second pair pending
  logic [7:0] portA_d, portB_d;
  logic outValid_d;
  logic [31:0] rdData_d;
  logic ack_d;
  logic ringWr_d;
  logic [31:0] ringWrData_d;

  // combinational helpers
  logic wordIn, ctrlWr, push, pop, fifoEmpty, fifoFull;
  logic [31:0] pushData, status, control;
  logic trigger;

  //============================================================
  // combinational decode
  always_comb begin
    wordIn = fpdpStrobe && fpdpDvalid && !linkRst_q;
    ctrlWr = regSel && regWrite && (regAddr == CONTROL_OFS);
    fifoEmpty = (level_q == '0);
    fifoFull = (level_q == FULL_LEVEL);
    // trigger source selection
    unique case (mode_q)
      MODE_EXT: trigger = startEvent;
      MODE_SW: trigger = ctrlWr && regWrData[CT_SW_TRIG];
      default: trigger = 1'b0;  // no action
    endcase
    // redirector, nothing routed while disabled
    push = 1'b0;
    pushData = fpdpData;
    ringWr_d = 1'b0;
    if (enable_q) begin
      unique case (route_q)
        ROUTE_BOTH: begin
          push = wordIn;
          ringWr_d = wordIn;
        end
        ROUTE_DAC: push = wordIn;
        ROUTE_RING2DAC: begin
          push = !fifoFull;
          pushData = ringRdData;
        end
        ROUTE_RING: ringWr_d = wordIn;
      endcase
    end
    ringWrData_d = fpdpData;
    // read only after start and between pairs
    pop = started_q && !secondHalf_q && enable_q;
    // status word
    status = '0;
    status[ST_OVERRUN] = overrun_q;
    status[ST_FULL] = fifoFull;
    status[ST_HALF] = (level_q >= HALF_LEVEL);
    status[ST_EMPTY] = fifoEmpty;
    status[ST_DVALID] = dvalidSeen_q;
    status[ST_START] = started_q;
    status[ST_LOCK] = clkLocked;
    control = '0;
    control[CT_MODE_HI:CT_MODE_LO] = mode_q;
    control[CT_LINK_RST] = linkRst_q;
    control[CT_ROUTE_HI:CT_ROUTE_LO] = route_q;
    control[CT_ENABLE] = enable_q;
  end

  //============================================================
  // next state
  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    level_d = level_q;
    overrun_d = overrun_q;
    dvalidSeen_d = dvalidSeen_q;
    started_d = started_q;
    mode_d = mode_q;
    route_d = route_q;
    linkRst_d = linkRst_q;
    enable_d = enable_q;
    boardRst_d = 1'b0;
    ringPtr_d = ringPtr_q;
    stopAddr_d = stopAddr_q;
    lastAddr_d = lastAddr_q;
    outWord_d = outWord_q;
    secondHalf_d = 1'b0;
    portA_d = portA;
    portB_d = portB;
    outValid_d = 1'b0;
    ack_d = regSel;
    rdData_d = '0;
    // register reads, unmapped read zero
    if (regSel && !regWrite) begin
      unique case (regAddr)
        STATUS_OFS: rdData_d = status;
        CONTROL_OFS: rdData_d = control;
        VERSION_OFS: rdData_d = {4'h0, UNIT_CODE, FW_VERSION};
        STOP_ADDR_OFS: rdData_d = 32'(stopAddr_q);
        LAST_ADDR_OFS: rdData_d = 32'(lastAddr_q);
        default: rdData_d = '0;
      endcase
    end
    // register writes, status ignores writes
    if (ctrlWr) begin
      mode_d = regWrData[CT_MODE_HI:CT_MODE_LO];
      route_d = regWrData[CT_ROUTE_HI:CT_ROUTE_LO];
      linkRst_d = regWrData[CT_LINK_RST];
      enable_d = regWrData[CT_ENABLE];
      boardRst_d = regWrData[CT_BOARD_RST];
    end
    if (regSel && regWrite && (regAddr == LAST_ADDR_OFS)) begin
      lastAddr_d = regWrData[RING_AW-1:0];
    end
    // data valid seen on the link
    if (linkRst_q) begin
      dvalidSeen_d = 1'b0;
    end else if (wordIn) begin
      dvalidSeen_d = 1'b1;
    end
    // start catch, new acquisition
    if (!enable_q || linkRst_q) begin
      started_d = 1'b0;
    end else if (trigger && !started_q) begin
      started_d = 1'b1;
    end
    // fifo bookkeeping
    if (push && fifoFull) begin
      overrun_d = 1'b1;
    end
    if (pop && fifoEmpty) begin
      overrun_d = 1'b1;
    end
    if (push && !fifoFull) begin
      wrPtr_d = wrPtr_q + 1'b1;
    end
    if (pop && !fifoEmpty) begin
      rdPtr_d = rdPtr_q + 1'b1;
      outWord_d = mem_q[rdPtr_q];
      portA_d = mem_q[rdPtr_q][31:24];
      portB_d = mem_q[rdPtr_q][23:16];
      outValid_d = 1'b1;
      secondHalf_d = 1'b1;
    end else if (secondHalf_q) begin
      portA_d = outWord_q[15:8];
      portB_d = outWord_q[7:0];
      outValid_d = 1'b1;
    end
    level_d = level_q + (DEPTH_LOG2+1)'(push && !fifoFull)
      - (DEPTH_LOG2+1)'(pop && !fifoEmpty);
    // ring address counter and stop address
    if (ringWr_d || (push && route_q == ROUTE_RING2DAC)) begin
      ringPtr_d = (ringPtr_q == lastAddr_q) ? '0 : ringPtr_q + 1'b1;
    end
    if (ringWr_d) begin
      stopAddr_d = ringPtr_q;
    end
    ringWrAddr_d = ringPtr_q;  // travels with the delayed write strobe
    // board reset restores defaults
    if (boardRst_q) begin
      wrPtr_d = '0;
      rdPtr_d = '0;
      level_d = '0;
      overrun_d = 1'b0;
      dvalidSeen_d = 1'b0;
      started_d = 1'b0;
      mode_d = MODE_RST;
      route_d = ROUTE_RST;
      linkRst_d = LINK_RST_RST;
      enable_d = 1'b0;
      ringPtr_d = '0;
      stopAddr_d = '0;
      lastAddr_d = LAST_ADDR_RST;
      secondHalf_d = 1'b0;
      outValid_d = 1'b0;
    end
  end

  //============================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
      overrun_q <= 1'b0;
      dvalidSeen_q <= 1'b0;
      started_q <= 1'b0;
      mode_q <= MODE_RST;
      route_q <= ROUTE_RST;
      linkRst_q <= LINK_RST_RST;
      enable_q <= 1'b0;
      boardRst_q <= 1'b0;
      ringPtr_q <= '0;
      stopAddr_q <= '0;
      lastAddr_q <= LAST_ADDR_RST;
      ringWrAddr_q <= '0;
      outWord_q <= '0;
      secondHalf_q <= 1'b0;
      portA <= '0;
      portB <= '0;
      outValid <= 1'b0;
      regRdData <= '0;
      regAck <= 1'b0;
      ringWrEn <= 1'b0;
      ringWrData <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      level_q <= level_d;
      overrun_q <= overrun_d;
      dvalidSeen_q <= dvalidSeen_d;
      started_q <= started_d;
      mode_q <= mode_d;
      route_q <= route_d;
      linkRst_q <= linkRst_d;
      enable_q <= enable_d;
      boardRst_q <= boardRst_d;
      ringPtr_q <= ringPtr_d;
      stopAddr_q <= stopAddr_d;
      lastAddr_q <= lastAddr_d;
      ringWrAddr_q <= ringWrAddr_d;
      outWord_q <= outWord_d;
      secondHalf_q <= secondHalf_d;
      portA <= portA_d;
      portB <= portB_d;
      outValid <= outValid_d;
      regRdData <= rdData_d;
      regAck <= ack_d;
      ringWrEn <= ringWr_d && !boardRst_q;
      ringWrData <= ringWrData_d;
    end
  end

  //============================================================
  // fifo storage, one write port per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge clk) begin
      if (push && !fifoFull && wrPtr_q == DEPTH_LOG2'(i)) begin
        mem_q[i] <= pushData;
      end
    end
  end

  //============================================================
  // outputs and LEDs
  // write strobe lags the pointer by a cycle, so it carries its own address
  assign ringAddr = ringWrEn ? ringWrAddr_q : ringPtr_q;
  assign linkReset = linkRst_q;
  assign ledClock = (clkLocked && !clkFault) ? LED_GREEN : LED_RED;
  assign ledBus = {regAck, regSel};
  // routing LED mirrors redirector code
  always_comb begin
    unique case (route_q)
      ROUTE_BOTH: ledRoute = LED_OFF;
      ROUTE_DAC: ledRoute = LED_GREEN;
      ROUTE_RING2DAC: ledRoute = LED_RED;
      ROUTE_RING: ledRoute = LED_YELLOW;
    endcase
  end

endmodule

/* File: test/dac_output_path_chk.sv */
`timescale 1ns/1ns
// ==========
// port checker for the output path
module dac_output_path_chk
  import dac_path_pkg::*;
#(
  parameter int RING_AW = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic regSel,
  input wire logic regWrite,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic [31:0] regRdData,
  input wire logic regAck,
  // health, ring, output
  input wire logic clkLocked,
  input wire logic clkFault,
  input wire logic ringWrEn,
  input wire logic [RING_AW-1:0] ringAddr,
  input wire logic outValid,
  // leds
  input wire logic [1:0] ledClock,
  input wire logic [1:0] ledBus,
  input wire logic [1:0] ledRoute
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========
  // leds, register answers, ring steps and output pairs
  property p_ledClk; ledClock == (clkLocked && !clkFault ? LED_GREEN : LED_RED); endproperty
  a_ledClk: assert property (p_ledClk) else $error("clock led wrong");
  property p_ledBus; ledBus == {regAck, regSel}; endproperty
  a_ledBus: assert property (p_ledBus) else $error("bus led wrong");
  property p_ack; regSel |=> regAck; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_noAck; !regSel |=> !regAck; endproperty
  a_noAck: assert property (p_noAck) else $error("ack without access");
  property p_route; regSel && regWrite && regAddr == CONTROL_OFS && !regWrData[31]
    |=> ledRoute == $past(regWrData[5:4]); endproperty
  a_route: assert property (p_route) else $error("route led wrong");
  property p_lock; regSel && !regWrite && regAddr == STATUS_OFS
    |=> regRdData[0] == $past(clkLocked); endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  property p_wrap; ringWrEn ##1 ringWrEn
    |-> ringAddr == $past(ringAddr) + 1'b1 || ringAddr == '0; endproperty
  a_wrap: assert property (p_wrap) else $error("ring step wrong");
  property p_pair; $rose(outValid) |=> outValid; endproperty
  a_pair: assert property (p_pair) else $error("pair cut short");
endmodule
bind dac_output_path dac_output_path_chk #(.RING_AW(RING_AW)) i_dac_output_path_chk (
  .clk(clk), .rst_b(rst_b), .regSel(regSel), .regWrite(regWrite), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .regAck(regAck), .clkLocked(clkLocked),
  .clkFault(clkFault), .ringWrEn(ringWrEn), .ringAddr(ringAddr), .outValid(outValid),
  .ledClock(ledClock), .ledBus(ledBus), .ledRoute(ledRoute));

/* File: test/fpdp_board_model.sv */
`timescale 1ns/1ns
// ==========
// daughter board stand-in, link master
module fpdp_board_model (
  // clock
  input wire logic clk,
  // link lines
  output logic [31:0] fpdpData,
  output logic fpdpDvalid,
  output logic fpdpStrobe
);
  // idle link; resync line never driven
  initial begin
    fpdpData = 32'h0;
    fpdpDvalid = 1'b0;
    fpdpStrobe = 1'b0;
  end
  // one word per edge, released after the last
  task automatic send(input logic [31:0] w, input logic last);
    fpdpData <= w;
    fpdpDvalid <= 1'b1;
    fpdpStrobe <= 1'b1;
    @(posedge clk);
    if (last) begin
      fpdpData <= ~w;
      fpdpDvalid <= 1'b0;
      fpdpStrobe <= 1'b0;
    end
  endtask
endmodule

/* File: test/fpdp_to_dac_output_path_test.sv */
`timescale 1ns/1ns
// ==========
// bench for the output path
module fpdp_to_dac_output_path_test;
  import dac_path_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic regSel, regWrite, regAck, fpdpDvalid, fpdpStrobe, linkReset;
  logic startEvent, clkLocked, clkFault, ringWrEn, outValid;
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, fpdpData, ringWrData, ringRdData, q, ringLast;
  logic [19:0] ringAddr, ringLastAddr;
  logic [7:0] portA, portB;
  logic [1:0] ledClock, ledBus, ledRoute;
  int err_count, n_tests, ringWrites;
  always #5 clk = ~clk;
  // ring memory stand-in, zero latency
  assign ringRdData = {4{ringAddr[7:0]}};
  // count ring writes, keep the last word and its address
  always @(posedge clk) if (ringWrEn === 1'b1) begin
    ringWrites <= ringWrites + 1;
    ringLast <= ringWrData;
    ringLastAddr <= ringAddr;
  end
  // eight addresses, so nine words wrap once, codes arbitrary
  dac_output_path #(.LAST_ADDR_RST(20'h00007), .UNIT_CODE(12'h3C4), .FW_VERSION(16'h0102))
  i_dac_output_path (.clk(clk), .rst_b(rst_b), .regSel(regSel), .regWrite(regWrite),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regAck(regAck),
    .fpdpData(fpdpData), .fpdpDvalid(fpdpDvalid), .fpdpStrobe(fpdpStrobe),
    .linkReset(linkReset), .startEvent(startEvent), .clkLocked(clkLocked),
    .clkFault(clkFault), .ringWrEn(ringWrEn), .ringAddr(ringAddr), .ringWrData(ringWrData),
    .ringRdData(ringRdData), .portA(portA), .portB(portB), .outValid(outValid),
    .ledClock(ledClock), .ledBus(ledBus), .ledRoute(ledRoute));
  fpdp_board_model i_fpdp_board_model (.clk(clk), .fpdpData(fpdpData),
    .fpdpDvalid(fpdpDvalid), .fpdpStrobe(fpdpStrobe));
  // ==========
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one register access, answer taken in the ack cycle
  task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regSel <= 1'b1;
    regWrite <= wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regSel <= 1'b0;
    #1;
    q = regRdData;
    chk({31'h0, regAck}, 32'h1);
  endtask
  // four samples, oldest in the top byte
  function automatic logic [31:0] wordOf(input int i);
    logic [7:0] b;
    b = 8'(4 * i);
    return {b, b + 8'h1, b + 8'h2, b + 8'h3};
  endfunction
  task automatic sendWords(input int s, input int n);
    @(posedge clk);
    for (int i = s; i < s + n; i++) i_fpdp_board_model.send(wordOf(i), i == s + n - 1);
  endtask
  // wait for a word, then check both pairs
  task automatic checkOut(input int i);
    logic [31:0] w;
    int k;
    w = wordOf(i);
    k = 0;
    while (outValid !== 1'b1 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (outValid !== 1'b1) begin
      chk(32'h0, 32'h1);
      conclude();
    end
    chk({16'h0, portA, portB}, {16'h0, w[31:16]});
    @(posedge clk);
    #1;
    chk({16'h0, portA, portB}, {16'h0, w[15:0]});
    @(posedge clk);
    #1;
  endtask
  // ==========
  // scenarios
  task automatic resetValues();
    rw(0, CONTROL_OFS, 0);
    chk(q, 32'h00001000);
    chk({31'h0, linkReset}, 32'h1);
    rw(0, VERSION_OFS, 0);
    chk(q, 32'h03C40102);
    rw(0, LAST_ADDR_OFS, 0);
    chk(q, 32'h7);
    rw(0, 12'h0F0, 0);
    chk(q, 32'h0);
    rw(1, STATUS_OFS, 32'hFFFFFFFF);
    rw(0, STATUS_OFS, 0);
    chk(q, 32'h01000001);
    @(posedge clk);
    clkLocked <= 1'b0;
    clkFault <= 1'b1;
    rw(0, STATUS_OFS, 0);
    chk(q, 32'h01000000);
    @(posedge clk);
    clkLocked <= 1'b1;
    clkFault <= 1'b0;
  endtask
  task automatic streamRun();
    rw(1, CONTROL_OFS, 32'h1);
    chk({31'h0, linkReset}, 32'h0);
    sendWords(0, 3);
    sendWords(3, 6);
    repeat (3) @(posedge clk);
    chk(ringWrites, 9);
    chk(ringLast, wordOf(8));
    chk({12'h0, ringLastAddr}, 32'h0);
    rw(0, STOP_ADDR_OFS, 0);
    chk(q, 32'h0);
    rw(0, STATUS_OFS, 0);
    chk(q, 32'h02200001);
    @(posedge clk);
    startEvent <= 1'b1;
    for (int i = 0; i < 9; i++) checkOut(i);
    repeat (4) @(posedge clk);
    rw(0, STATUS_OFS, 0);
    chk(q, 32'h09210001);
    @(posedge clk);
    startEvent <= 1'b0;
  endtask
  task automatic routeTable();
    logic [31:0] ctl [4] = '{32'h11, 32'h31, 32'h21, 32'h0};
    int wr [4] = '{0, 2, 0, 0};
    logic [2:0] em [4] = '{3'b000, 3'b001, 3'b110, 3'b001};
    for (int r = 0; r < 4; r++) begin
      rw(1, CONTROL_OFS, 32'h80000000);
      rw(0, CONTROL_OFS, 0);
      chk(q, 32'h00001000);
      rw(1, CONTROL_OFS, ctl[r]);
      ringWrites = 0;
      sendWords(0, 2);
      repeat (19) @(posedge clk);
      chk(ringWrites, wr[r]);
      rw(0, STATUS_OFS, 0);
      chk({29'h0, q[26:24]}, {29'h0, em[r]});
    end
  endtask
  task automatic triggerModes();
    logic st [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic s0 [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    @(posedge clk);
    startEvent <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      rw(1, CONTROL_OFS, 32'h80000000);
      rw(1, CONTROL_OFS, 32'h11 | (32'(m) << 20));
      rw(0, STATUS_OFS, 0);
      chk({31'h0, q[16]}, {31'h0, s0[m]});
      rw(1, CONTROL_OFS, 32'h111 | (32'(m) << 20));
      rw(0, STATUS_OFS, 0);
      chk({31'h0, q[16]}, {31'h0, st[m]});
    end
  endtask
  // main sequence
  initial begin
    regSel = 1'b0;
    regWrite = 1'b0;
    regAddr = 12'h0;
    regWrData = 32'h0;
    startEvent = 1'b0;
    clkLocked = 1'b1;
    clkFault = 1'b0;
    err_count = 0;
    n_tests = 0;
    ringWrites = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    resetValues();
    streamRun();
    routeTable();
    triggerModes();
    conclude();
  end
endmodule
